// *** hw/slcu_pkg.sv ***
package slcu_pkg;
  // frequencies in 0.01 Hz, percentages in 0.1 %, times in 0.1 s
  localparam int          FREQ_W          = 16;
  localparam int          PCT_W           = 10;
  localparam logic [9:0]  PCT_FULL        = 10'h3e8;
  localparam logic [9:0]  SWING_PCT_RST   = 10'h000;
  localparam logic [9:0]  JUMP_PCT_MAX    = 10'h1f4;
  localparam logic [9:0]  JUMP_PCT_RST    = 10'h000;
  localparam logic [9:0]  RISE_PCT_RST    = 10'h1f4;
  localparam logic [15:0] PERIOD_MAX      = 16'h7530;
  localparam logic [15:0] PERIOD_RST      = 16'h0064;
  localparam logic        BASE_CENTRAL    = 1'b0;
  localparam logic        BASE_MAXIMUM    = 1'b1;
  localparam logic        BASE_RST        = 1'b0;
  localparam logic [15:0] SET_LEN_RST     = 16'h03e8;
  localparam logic [15:0] PPM_RST         = 16'h03e8;
  localparam logic [15:0] PPM_MIN         = 16'h0001;
  localparam logic [15:0] SET_CNT_RST     = 16'h03e8;
  localparam logic [15:0] DESIG_CNT_RST   = 16'h03e8;
  localparam int          CLK_HZ          = 25000000;
  localparam int          TICK_MS         = 1;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int          MS_PER_TENTH    = 100;

  typedef enum logic [1:0] {
    SLCU_IDLE = 2'b00,
    SLCU_RISE = 2'b01,
    SLCU_FALL = 2'b11
  } slcu_state_t;

  typedef struct packed {
    logic        base_sel;
    logic [9:0]  swing_pct;
    logic [9:0]  jump_pct;
    logic [15:0] period;
    logic [9:0]  rise_pct;
  } slcu_swing_cfg_t;

  typedef struct packed {
    logic [15:0] f_center;
    logic [15:0] f_max;
    logic [15:0] f_upper;
    logic [15:0] f_lower;
  } slcu_freq_t;
endpackage

// *** hw/slcu_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - zero amplitude percentage means no swing
// - base selector picks central or maximum frequency
// - base 0: amplitude is centre times percentage
// - base 1: amplitude is maximum times percentage
// - jump is amplitude times jump percentage
// - clamp output between lower and upper limits while swinging; idle output is the centre
// - one swing cycle lasts configured period
// - rise time is period times coefficient
// - fall time is period times remainder
// - length is pulses divided by pulses-per-metre
// - length-reached output once length exceeds set
// - length-reset input clears actual length
// - set count reached: output on, stop
// - designated count reached: output on, continue
module slcu_top #(
  parameter int TICK_CYCLES_P = slcu_pkg::TICK_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      run_cmd,
  input  wire slcu_pkg::slcu_swing_cfg_t swing_cfg,
  input  wire slcu_pkg::slcu_freq_t      freq,
  input  wire logic                      length_pulse_in,
  input  wire logic                      length_reset_in,
  input  wire logic                      count_pulse_in,
  input  wire logic                      count_reset_in,
  input  wire logic [15:0]               set_length,
  input  wire logic [15:0]               pulses_per_metre,
  input  wire logic [15:0]               set_count,
  input  wire logic [15:0]               designated_count,
  output logic [15:0]                    out_freq,
  output logic [15:0]                    actual_swing_amplitude,
  output logic [15:0]                    actual_length,
  output logic                           length_reached,
  output logic [15:0]                    count_value,
  output logic                           set_count_reached,
  output logic                           designated_count_reached
);
  import slcu_pkg::*;

  // three-stage synchronisers for the pin inputs; change counted when stages 2 and 3 agree
  logic [2:0] sync_lp, sync_lr, sync_cp, sync_cr;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_lp <= 3'h0;
      sync_lr <= 3'h0;
      sync_cp <= 3'h0;
      sync_cr <= 3'h0;
    end else begin
      sync_lp <= {sync_lp[1:0], length_pulse_in};
      sync_lr <= {sync_lr[1:0], length_reset_in};
      sync_cp <= {sync_cp[1:0], count_pulse_in};
      sync_cr <= {sync_cr[1:0], count_reset_in};
    end
  end

  logic lp_lvl, lr_lvl, cp_lvl, cr_lvl;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lp_lvl <= 1'b0;
      lr_lvl <= 1'b0;
      cp_lvl <= 1'b0;
      cr_lvl <= 1'b0;
    end else begin
      if (sync_lp[1] == sync_lp[2]) lp_lvl <= sync_lp[2];
      if (sync_lr[1] == sync_lr[2]) lr_lvl <= sync_lr[2];
      if (sync_cp[1] == sync_cp[2]) cp_lvl <= sync_cp[2];
      if (sync_cr[1] == sync_cr[2]) cr_lvl <= sync_cr[2];
    end
  end

  logic lp_rise, cp_rise;
  always_comb begin
    lp_rise = (sync_lp[2] == sync_lp[1]) && sync_lp[2] && !lp_lvl;
    cp_rise = (sync_cp[2] == sync_cp[1]) && sync_cp[2] && !cp_lvl;
  end

  // length: whole metres from a pulse remainder counter; ppm is in tenths, so
  // each pulse adds ten units to pulse_acc, and ppm_eff units make one metre
  logic [31:0] pulse_acc;
  logic [15:0] ppm_eff;
  assign ppm_eff = (pulses_per_metre < PPM_MIN) ? PPM_MIN : pulses_per_metre;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_acc     <= 32'h0;
      actual_length <= 16'h0;
    end else if (lr_lvl) begin
      pulse_acc     <= 32'h0;
      actual_length <= 16'h0;
    end else if (lp_rise) begin
      if (pulse_acc + 32'd10 >= {16'h0, ppm_eff}) begin
        pulse_acc     <= pulse_acc + 32'd10 - {16'h0, ppm_eff};
        if (actual_length != 16'hffff) actual_length <= actual_length + 16'h1;
      end else begin
        pulse_acc <= pulse_acc + 32'd10;
      end
    end
  end
  assign length_reached = (actual_length > set_length);

  // counter: stops at set count when set count is nonzero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_value <= 16'h0;
    end else if (cr_lvl) begin
      count_value <= 16'h0;
    end else if (cp_rise && !set_count_reached) begin
      count_value <= count_value + 16'h1;
    end
  end
  assign set_count_reached        = (count_value >= set_count) && (set_count != 16'h0);
  // designated at or below set is the configurer's duty; flag holds once reached
  assign designated_count_reached = (count_value >= designated_count)
                                    && (designated_count != 16'h0);

  // swing amplitude and jump, in 0.01 Hz
  logic [15:0] base_freq;
  logic [25:0] amp_prod;
  logic [25:0] jump_prod;
  logic [15:0] jump_freq;
  logic [9:0]  swing_pct_c, jump_pct_c, rise_pct_c;
  always_comb begin
    swing_pct_c = (swing_cfg.swing_pct > PCT_FULL) ? PCT_FULL : swing_cfg.swing_pct;
    jump_pct_c  = (swing_cfg.jump_pct > JUMP_PCT_MAX) ? JUMP_PCT_MAX : swing_cfg.jump_pct;
    rise_pct_c  = (swing_cfg.rise_pct > PCT_FULL) ? PCT_FULL : swing_cfg.rise_pct;
    base_freq   = (swing_cfg.base_sel == BASE_MAXIMUM) ? freq.f_max : freq.f_center;
    amp_prod    = base_freq * swing_pct_c;
    jump_prod   = actual_swing_amplitude * jump_pct_c;
    jump_freq   = 16'(jump_prod / 26'(PCT_FULL));
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) actual_swing_amplitude <= 16'h0;
    else       actual_swing_amplitude <= 16'(amp_prod / 26'(PCT_FULL));
  end

  // millisecond tick and ramp timing
  logic [31:0] tick_cnt;
  logic        tick;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) tick_cnt <= 32'h0;
    else if (tick) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end
  assign tick = (tick_cnt >= 32'(TICK_CYCLES_P - 1));

  logic [15:0] period_c;
  logic [31:0] rise_ms, fall_ms, period_ms;
  always_comb begin
    period_c  = (swing_cfg.period > PERIOD_MAX) ? PERIOD_MAX : swing_cfg.period;
    period_ms = period_c * 32'(MS_PER_TENTH);
    rise_ms   = period_ms * rise_pct_c / 32'(PCT_FULL);
    fall_ms   = period_ms - rise_ms;
  end

  slcu_state_t state;
  logic [31:0] phase_ms;
  logic        swing_on;
  assign swing_on = run_cmd && (swing_pct_c != 10'h0) && (period_ms != 32'h0);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state    <= SLCU_IDLE;
      phase_ms <= 32'h0;
    end else if (!swing_on) begin
      state    <= SLCU_IDLE;
      phase_ms <= 32'h0;
    end else begin
      case (state)
        SLCU_IDLE: begin
          state    <= SLCU_RISE;
          phase_ms <= 32'h0;
        end
        SLCU_RISE: begin
          if (tick) begin
            if (phase_ms + 32'h1 >= rise_ms) begin
              state    <= SLCU_FALL;
              phase_ms <= 32'h0;
            end else phase_ms <= phase_ms + 32'h1;
          end
        end
        SLCU_FALL: begin
          if (tick) begin
            if (phase_ms + 32'h1 >= fall_ms) begin
              state    <= SLCU_RISE;
              phase_ms <= 32'h0;
            end else phase_ms <= phase_ms + 32'h1;
          end
        end
        default: state <= SLCU_IDLE;
      endcase
    end
  end

  // offset runs from -amp to +amp on the rise, after the jump step back at each turn
  logic signed [18:0] offset;
  logic [47:0]        ramp_num;
  logic [16:0]        span;
  logic [16:0]        travel;
  logic signed [18:0] raw_freq;
  always_comb begin
    // span shortened by the jump so each ramp ends on the opposite amplitude, never beyond it
    span     = {actual_swing_amplitude, 1'b0} - {1'b0, jump_freq};
    ramp_num = 48'h0;
    travel   = 17'h0;
    offset   = 19'sh0;
    case (state)
      SLCU_RISE: begin
        ramp_num = (rise_ms == 32'h0) ? 48'h0 : ({31'h0, span} * phase_ms) / rise_ms;
        travel   = ramp_num[16:0];
        // start from -amp+jump: the step back after the falling turn
        offset   = -$signed({2'b00, actual_swing_amplitude}) + $signed({2'b00, jump_freq})
                   + $signed({2'b00, travel});
      end
      SLCU_FALL: begin
        ramp_num = (fall_ms == 32'h0) ? 48'h0 : ({31'h0, span} * phase_ms) / fall_ms;
        travel   = ramp_num[16:0];
        offset   = $signed({2'b00, actual_swing_amplitude}) - $signed({2'b00, jump_freq})
                   - $signed({2'b00, travel});
      end
      default: offset = 19'sh0;
    endcase
    raw_freq = $signed({3'b000, freq.f_center}) + offset;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_freq <= 16'h0;
    end else if (state == SLCU_IDLE) begin
      out_freq <= freq.f_center;
    end else if (raw_freq > $signed({3'b000, freq.f_upper})) begin
      out_freq <= freq.f_upper;
    end else if (raw_freq < $signed({3'b000, freq.f_lower})) begin
      out_freq <= freq.f_lower;
    end else begin
      out_freq <= raw_freq[15:0];
    end
  end
endmodule

// *** dv/slcu_pulse_src.sv ***
`timescale 1ns/1ps
// far-side pulse source: n pulses of 4 cycles high, 4 low, pin low when idle
module slcu_pulse_src (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic [15:0] n,
  output logic             pin,
  output logic             busy
);
  logic [15:0] left;
  logic [2:0]  ph;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      left <= 16'h0000;
      ph   <= 3'h0;
    end else if (go) begin
      left <= n;
      ph   <= 3'h0;
    end else if (left != 16'h0000) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) left <= left - 16'h0001;
    end
  end
  // high and low phases both exceed the three-stage filter
  assign pin  = (left != 16'h0000) && !ph[2];
  assign busy = (left != 16'h0000);
endmodule

// *** dv/slcu_top_asserts.sv ***
`timescale 1ns/1ps
module slcu_top_asserts
  import slcu_pkg::*;
(
  input wire logic                      core_clk,
  input wire logic                      rstn,
  input wire logic                      run_cmd,
  input wire slcu_pkg::slcu_swing_cfg_t swing_cfg,
  input wire slcu_pkg::slcu_freq_t      freq,
  input wire logic                      length_reset_in,
  input wire logic [15:0]               set_length,
  input wire logic [15:0]               set_count,
  input wire logic [15:0]               designated_count,
  input wire logic [15:0]               out_freq,
  input wire logic [15:0]               actual_swing_amplitude,
  input wire logic [15:0]               actual_length,
  input wire logic                      length_reached,
  input wire logic [15:0]               count_value,
  input wire logic                      set_count_reached,
  input wire logic                      designated_count_reached
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_no_swing_out: assert property (swing_cfg.swing_pct == 10'h000 [*3]
    |-> out_freq == freq.f_center) else $error("output moved with zero swing");
  chk_amp_from_center: assert property ($past(rstn) && $stable(swing_cfg) && $stable(freq)
    && swing_cfg.base_sel == BASE_CENTRAL |-> actual_swing_amplitude ==
    16'(32'(freq.f_center) * swing_cfg.swing_pct / PCT_FULL)) else $error("central amplitude");
  chk_amp_from_max: assert property ($past(rstn) && $stable(swing_cfg) && $stable(freq)
    && swing_cfg.base_sel == BASE_MAXIMUM |-> actual_swing_amplitude ==
    16'(32'(freq.f_max) * swing_cfg.swing_pct / PCT_FULL)) else $error("fixed amplitude");
  chk_clamp_band: assert property (run_cmd && $past(run_cmd) && $stable(freq)
    |-> out_freq <= freq.f_upper && out_freq >= freq.f_lower) else $error("output out of band");
  chk_len_flag: assert property (length_reached == (actual_length > set_length))
    else $error("length flag wrong");
  chk_len_clear: assert property (length_reset_in [*6] |-> actual_length == 16'h0000)
    else $error("length not cleared");
  chk_set_stop: assert property (count_value == set_count |-> set_count_reached
    ##1 count_value <= $past(count_value)) else $error("set count not held");
  chk_desig_flag: assert property (count_value == designated_count && count_value < set_count
    |-> designated_count_reached && !set_count_reached) else $error("designated flag wrong");
endmodule
bind slcu_top slcu_top_asserts u_chk (.core_clk, .rstn, .run_cmd, .swing_cfg, .freq,
  .length_reset_in, .set_length, .set_count, .designated_count, .out_freq,
  .actual_swing_amplitude, .actual_length, .length_reached, .count_value,
  .set_count_reached, .designated_count_reached);

// *** dv/tb_swing_length_count_unit.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_swing_length_count_unit;
  import slcu_pkg::*;
  logic            core_clk, rstn, run_cmd, len_rst, cnt_rst, len_go, cnt_go, mon;
  logic            len_pin, cnt_pin, len_busy, cnt_busy, len_hit, set_hit, desig_hit;
  logic [15:0]     set_length, ppm, set_count, desig, len_n, cnt_n, hi, lo;
  logic [15:0]     out_freq, amp, act_len, cnt_val, prev;
  slcu_swing_cfg_t swing_cfg;
  slcu_freq_t      freq;
  int              err_total, comparisons, cyc, ups, downs;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // short tick keeps a swing period at 400 cycles
  slcu_top #(.TICK_CYCLES_P(4)) dut (.core_clk, .rstn, .run_cmd, .swing_cfg, .freq,
    .length_pulse_in(len_pin), .length_reset_in(len_rst), .count_pulse_in(cnt_pin),
    .count_reset_in(cnt_rst), .set_length, .pulses_per_metre(ppm), .set_count,
    .designated_count(desig), .out_freq, .actual_swing_amplitude(amp), .actual_length(act_len),
    .length_reached(len_hit), .count_value(cnt_val), .set_count_reached(set_hit),
    .designated_count_reached(desig_hit));
  slcu_pulse_src u_len (.core_clk, .rstn, .go(len_go), .n(len_n), .pin(len_pin), .busy(len_busy));
  slcu_pulse_src u_cnt (.core_clk, .rstn, .go(cnt_go), .n(cnt_n), .pin(cnt_pin), .busy(cnt_busy));
  task give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (mon && out_freq > hi) hi = out_freq;
    if (mon && out_freq < lo) lo = out_freq;
    // every ramp millisecond moves the output once, turns included
    if (mon && out_freq > prev) ups++;
    if (mon && out_freq < prev) downs++;
    prev = out_freq;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task hold(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task pulses(input logic sel, input logic [15:0] n);
    int k;
    @(posedge core_clk);
    if (sel) begin cnt_n <= n; cnt_go <= 1'b1; end
    else begin len_n <= n; len_go <= 1'b1; end
    @(posedge core_clk);
    len_go <= 1'b0;
    cnt_go <= 1'b0;
    @(posedge core_clk);
    for (k = 0; k < 2000 && (len_busy | cnt_busy) !== 1'b0; k++) @(posedge core_clk);
    hold(8);
  endtask
  initial begin
    {rstn, run_cmd, len_rst, cnt_rst, len_go, cnt_go, mon} = 7'h00;
    {len_n, cnt_n, cyc, err_total, comparisons} = '0;
    swing_cfg = '{BASE_CENTRAL, 10'h000, 10'h000, 16'h0001, RISE_PCT_RST};
    freq = '{16'h1388, 16'h2710, 16'h16a8, 16'h1068};
    {set_length, ppm, set_count, desig} = {16'h0001, 16'h0019, 16'h0005, 16'h0003};
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    run_cmd <= 1'b1;
    hold(20);
    `CHK("out_freq", freq.f_center, out_freq)
    $display("test no_swing done");
    pulses(1'b0, 16'h0003);
    `CHK("actual_length", 16'h0001, act_len)
    `CHK("length_reached", 1'b0, len_hit)
    pulses(1'b0, 16'h0002);
    `CHK("actual_length", 16'h0002, act_len)
    `CHK("length_reached", 1'b1, len_hit)
    @(posedge core_clk) len_rst <= 1'b1;
    hold(10);
    @(posedge core_clk) len_rst <= 1'b0;
    hold(2);
    `CHK("actual_length", 16'h0000, act_len)
    $display("test length done");
    pulses(1'b1, 16'h0003);
    `CHK("designated_reached", 1'b1, desig_hit)
    `CHK("set_reached", 1'b0, set_hit)
    pulses(1'b1, 16'h0004);
    `CHK("count_value", 16'h0005, cnt_val)
    `CHK("set_reached", 1'b1, set_hit)
    @(posedge core_clk) cnt_rst <= 1'b1;
    hold(10);
    @(posedge core_clk) cnt_rst <= 1'b0;
    hold(2);
    `CHK("count_value", 16'h0000, cnt_val)
    $display("test count done");
    @(posedge core_clk) swing_cfg.swing_pct <= 10'h064;
    hold(4);
    `CHK("amplitude", 16'h01f4, amp)
    @(posedge core_clk) swing_cfg.base_sel <= BASE_MAXIMUM;
    swing_cfg.jump_pct <= 10'h064;
    hold(4);
    `CHK("amplitude", 16'h03e8, amp)
    hi = 16'h0000;
    lo = 16'hffff;
    mon = 1'b1;
    hold(900);
    mon = 1'b0;
    `CHK("swing_high", freq.f_upper, hi)
    `CHK("swing_low", freq.f_lower, lo)
    @(posedge core_clk) run_cmd <= 1'b0;
    hold(4);
    `CHK("out_freq", freq.f_center, out_freq)
    $display("test swing done");
    // wide band so no clamp; rise 25 % of a 100 ms period gives 25 ms up, 75 ms down
    @(posedge core_clk) freq <= '{16'h1388, 16'h2710, 16'h2710, 16'h0000};
    swing_cfg <= '{BASE_MAXIMUM, 10'h064, 10'h064, 16'h0001, 10'h0fa};
    hold(4);
    @(posedge core_clk) run_cmd <= 1'b1;
    hold(2);
    `CHK("swing_start", 16'h1004, out_freq)
    hold(410);
    ups = 0;
    downs = 0;
    mon = 1'b1;
    hold(400);
    mon = 1'b0;
    `CHK("rise_steps", 25, ups)
    `CHK("fall_steps", 75, downs)
    $display("test swing_timing done");
    give_verdict();
  end
endmodule
